// file: smps_pkg.sv
// constants, register map and states of the stop mode power-fail sequencer
// Summary of operation
// R1: stop halts cpu, keeps state and memories
// R2: io irq or warning wakes; fail resets
// R3: 8 kHz ring clock drives wake-up timer
// R4: wake period in 125 us steps, ~8 s
// R5: monitor always on outside stop mode; code turns it off in por and between periodic samples
// R6: stop monitor-off bit resets to one
// R7: monitor off in stop ignores warning, reset
// R8: por reset still generated in stop
// R9: monitor re-enabled before stop exit completes
// R10: exit check sets flag or resets cpu
// R11: after fail reset, continuous or periodic sampling
// R12: sample two ring cycles, confirm one more
// R13: confirmed supply: warm crystal, start 8000h
// R14: other resets keep monitor, regulator, crystal on
// R15: other resets release within 20 cycles
// R16: persistent warning sets flag, cpu keeps running
// R17: fail: reset, regulator and crystal off, periodic
// R18: below por: held in reset, nothing runs
// R19: software may enter stop at any time
// R20: two-bit interval: continuous, 2^11, 2^12, 2^13
package smps_pkg;
    localparam int CLK_PS = 4000;             // 250 MHz pclk
    localparam int XTAL_WARM_NS = 500000;     // crystal_warmup_time
    localparam int WARN_HOLD_NS = 10000;      // warning persistence time
    localparam int WARN_CYC = (WARN_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int EXT_LIMIT_CYC = 20;        // non-fail reset release bound
    localparam int SYNC_LAT_CYC = 4;          // pin to filtered level
    localparam int EXT_REL_CYC = EXT_LIMIT_CYC - SYNC_LAT_CYC - 4;
    localparam int SAMPLE_TICKS = 2;          // detector on, ring periods
    localparam int PER_LOG2_BASE = 10;        // select n gives 2^(10+n)
    localparam logic [15:0] ROM_ENTRY = 16'h8000;
    localparam logic [15:0] BOOT_RST = 16'h0000;
    // apb byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;    // power_control_register
    localparam logic [7:0] A_WAKE = 8'h04;
    localparam logic [7:0] A_CMD = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0c;
    // power_control_register fields
    localparam int B_MONOFF = 0;              // stop_monitor_off
    localparam int B_SEL = 1;                 // two bits, interval select
    localparam int B_WIE = 3;                 // warning interrupt enable
    localparam logic [3:0] CTRL_RST = 4'h1;
    localparam int B_WEN = 16;                // wake timer enable
    localparam logic [16:0] WAKE_RST = 17'h00000;
    localparam int B_STOP = 0;                // command: enter stop
    // status flags, write one to clear
    localparam int B_WFLAG = 0;               // supply_warning_flag
    localparam int B_TFLAG = 1;               // woken by timer
    localparam int B_PFLAG = 2;               // power-fail reset seen
    localparam logic [2:0] FLAG_RST = 3'h0;
    // pin vector positions and levels held during reset
    localparam int PIN_N = 6;
    localparam int P_RING = 0;
    localparam int P_POR = 1;
    localparam int P_RST = 2;
    localparam int P_WARN = 3;
    localparam int P_IRQ = 4;
    localparam int P_XRSTN = 5;
    localparam logic [5:0] PIN_RST = 6'h20;
    // {cpu_reset, cpu_halt, monitor_on, regulator_on, crystal_on, sram_retain}
    localparam logic [5:0] OUT_RST = 6'h20;
    typedef enum logic [3:0] {
        ST_POR, ST_XTAL, ST_RUN, ST_STOP, ST_WAKE,
        ST_PFWAIT, ST_SAMPLE, ST_CONFIRM, ST_EXTRST
    } smps_state_t;
endpackage : smps_pkg

// file: smps_top.sv
// stop mode and power-fail sequencer with apb register slave
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module smps_top #(
    parameter int XTAL_CYC = (smps_pkg::XTAL_WARM_NS * 1000 + smps_pkg::CLK_PS - 1)
        / smps_pkg::CLK_PS,
    parameter int CNT_W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ring_osc,     // 8 kHz ring oscillator
    input wire logic por_low,      // supply below por_threshold
    input wire logic rst_low,      // supply below reset_threshold
    input wire logic warn_low,     // supply below warning_threshold
    input wire logic ext_irq,
    input wire logic ext_reset_n,
    input wire logic wdt_reset,    // watchdog, same clock
    output logic cpu_reset,
    output logic cpu_halt,
    output logic monitor_on,
    output logic regulator_on,
    output logic crystal_on,
    output logic sram_retain,
    output logic warn_irq,
    output logic [15:0] boot_addr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    smps_pkg::smps_state_t state_r, state_nxt;
    logic [3:0] ctrl_r;
    logic [16:0] wake_r;
    logic [2:0] flag_r, flag_set, flag_clr;
    logic [CNT_W-1:0] cyc_r, warn_cnt_r;
    logic [13:0] tick_r;
    logic [15:0] wcnt_r, boot_r;
    logic [5:0] out_r;
    logic pready_r, pslverr_r, wirq_r, ring_d_r, seen_r;
    logic [31:0] prdata_r, rd_mux;
    logic [smps_pkg::PIN_N-1:0] pin_f;
    logic rst_o, halt_o, mon_o, pwr_o;

    wire logic [smps_pkg::PIN_N-1:0] pin_raw =
        {ext_reset_n, ext_irq, warn_low, rst_low, por_low, ring_osc};

    // every pin passes three stages; stage 1 feeds stage 2 only
    genvar gi;
    generate
        for (gi = 0; gi < smps_pkg::PIN_N; gi++) begin : g_sync
            logic [2:0] sh_r;
            logic flt_r;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sh_r <= {3{smps_pkg::PIN_RST[gi]}};
                    flt_r <= smps_pkg::PIN_RST[gi];
                end else begin
                    sh_r <= {sh_r[1:0], pin_raw[gi]};
                    if (sh_r[1] == sh_r[2]) begin
                        flt_r <= sh_r[2];  // glitch shorter than a cycle is dropped
                    end
                end
            end
            assign pin_f[gi] = flt_r;
        end
    endgenerate

    wire logic por_f = pin_f[smps_pkg::P_POR];
    wire logic rst_f = pin_f[smps_pkg::P_RST];
    wire logic warn_f = pin_f[smps_pkg::P_WARN];
    wire logic irq_f = pin_f[smps_pkg::P_IRQ];
    wire logic xrst_f = ~pin_f[smps_pkg::P_XRSTN] | wdt_reset;
    wire logic tick = pin_f[smps_pkg::P_RING] & ~ring_d_r;  // one per 125 us
    wire logic [1:0] sel = ctrl_r[smps_pkg::B_SEL +: 2];
    wire logic mon_stop = ~ctrl_r[smps_pkg::B_MONOFF];
    wire logic acc = psel & penable & ~pready_r;
    wire logic wr = psel & penable & pready_r & pwrite;
    wire logic stop_req = wr && paddr == smps_pkg::A_CMD && pwdata[smps_pkg::B_STOP];
    wire logic wake_done = cyc_r == CNT_W'(XTAL_CYC - 1);
    wire logic wake_hit = wake_r[smps_pkg::B_WEN] && wake_r[15:0] != 16'h0 && tick
        && wcnt_r == wake_r[15:0] - 16'h1;

    // last ring tick of a periodic interval
    function automatic logic [13:0] per_last(input logic [1:0] s);
        per_last = 14'((1 << (smps_pkg::PER_LOG2_BASE + int'(s))) - 1);
    endfunction : per_last

    // sequencer; a supply below por overrides every state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            smps_pkg::ST_POR: begin
                state_nxt = smps_pkg::ST_XTAL;
            end
            smps_pkg::ST_XTAL: begin
                if (wake_done) begin
                    state_nxt = smps_pkg::ST_RUN;  // [R13]
                end
            end
            smps_pkg::ST_RUN: begin
                if (rst_f) begin
                    state_nxt = smps_pkg::ST_PFWAIT;  // [R17]
                end else if (xrst_f) begin
                    state_nxt = smps_pkg::ST_EXTRST;
                end else if (stop_req) begin
                    state_nxt = smps_pkg::ST_STOP;  // [R19]
                end
            end
            smps_pkg::ST_STOP: begin
                // with the monitor off, the reset and warning levels are not looked at; por still is
                if (mon_stop && rst_f) begin
                    state_nxt = smps_pkg::ST_PFWAIT;  // [R2] [R7]
                end else if (xrst_f) begin
                    state_nxt = smps_pkg::ST_EXTRST;
                end else if (irq_f || wake_hit || (mon_stop && warn_f)) begin
                    state_nxt = smps_pkg::ST_WAKE;  // [R2] [R3]
                end
            end
            smps_pkg::ST_WAKE: begin
                if (wake_done) begin
                    state_nxt = rst_f ? smps_pkg::ST_PFWAIT : smps_pkg::ST_RUN;  // [R10]
                end
            end
            smps_pkg::ST_PFWAIT: begin
                if (sel == 2'h0 || (tick && tick_r == per_last(sel))) begin
                    state_nxt = smps_pkg::ST_SAMPLE;  // [R11] [R20]
                end
            end
            smps_pkg::ST_SAMPLE: begin
                if (tick && tick_r == 14'(smps_pkg::SAMPLE_TICKS - 1)) begin
                    state_nxt = rst_f ? smps_pkg::ST_PFWAIT : smps_pkg::ST_CONFIRM;  // [R12]
                end
            end
            smps_pkg::ST_CONFIRM: begin
                if (rst_f) begin
                    state_nxt = smps_pkg::ST_PFWAIT;
                end else if (tick) begin
                    state_nxt = smps_pkg::ST_XTAL;  // [R12] [R13]
                end
            end
            smps_pkg::ST_EXTRST: begin
                if (!xrst_f && cyc_r == CNT_W'(smps_pkg::EXT_REL_CYC - 1)) begin
                    state_nxt = smps_pkg::ST_RUN;  // [R15]
                end
            end
            default: begin
                state_nxt = smps_pkg::ST_POR;
            end
        endcase
        if (por_f) begin
            state_nxt = smps_pkg::ST_POR;  // [R8] [R18]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= smps_pkg::ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // cycle and ring counters restart on every state change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_r <= '0;
            tick_r <= '0;
            wcnt_r <= '0;
            ring_d_r <= 1'b0;
        end else begin
            ring_d_r <= pin_f[smps_pkg::P_RING];
            if (state_nxt != state_r || (state_r == smps_pkg::ST_EXTRST && xrst_f)) begin
                cyc_r <= '0;
            end else begin
                cyc_r <= cyc_r + 1'b1;
            end
            if (state_nxt != state_r) begin
                tick_r <= '0;
            end else if (tick) begin
                tick_r <= tick_r + 1'b1;
            end
            if (state_r != smps_pkg::ST_STOP) begin
                wcnt_r <= '0;
            end else if (tick) begin
                wcnt_r <= wcnt_r + 16'h1;  // [R3] [R4]
            end
        end
    end

    // warning must persist before the flag is raised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_cnt_r <= '0;
        end else if (state_r == smps_pkg::ST_RUN && warn_f && !rst_f) begin
            if (warn_cnt_r != CNT_W'(smps_pkg::WARN_CYC - 1)) begin
                warn_cnt_r <= warn_cnt_r + 1'b1;  // [R16]
            end
        end else begin
            warn_cnt_r <= '0;
        end
    end

    // sticky status, a set in the clearing cycle wins
    always_comb begin
        flag_set = 3'h0;
        flag_set[smps_pkg::B_WFLAG] = (state_r == smps_pkg::ST_RUN && !rst_f && warn_f
            && warn_cnt_r == CNT_W'(smps_pkg::WARN_CYC - 1))  // [R16]
            || (state_r == smps_pkg::ST_WAKE && wake_done && warn_f && !rst_f);  // [R10]
        flag_set[smps_pkg::B_TFLAG] = state_r == smps_pkg::ST_STOP && wake_hit;
        flag_set[smps_pkg::B_PFLAG] = state_nxt == smps_pkg::ST_PFWAIT
            && state_r inside {smps_pkg::ST_RUN, smps_pkg::ST_STOP, smps_pkg::ST_WAKE};
        flag_clr = (wr && paddr == smps_pkg::A_STAT) ? pwdata[2:0] : 3'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= smps_pkg::FLAG_RST;
            wirq_r <= 1'b0;
        end else begin
            flag_r <= flag_set | (flag_r & ~flag_clr);
            wirq_r <= (flag_set[smps_pkg::B_WFLAG] | (flag_r[smps_pkg::B_WFLAG]
                & ~flag_clr[smps_pkg::B_WFLAG])) & ctrl_r[smps_pkg::B_WIE];  // [R16]
        end
    end

    // control writes; monitor-off only matters in stop, run ignores it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= smps_pkg::CTRL_RST;  // [R6]
            wake_r <= smps_pkg::WAKE_RST;
        end else if (wr) begin
            if (paddr == smps_pkg::A_CTRL) begin
                ctrl_r <= pwdata[3:0];
            end
            if (paddr == smps_pkg::A_WAKE) begin
                wake_r <= pwdata[16:0];  // [R4]
            end
        end
    end

    // power controls, registered from the next state so they line up with it
    always_comb begin
        rst_o = state_nxt inside {smps_pkg::ST_POR, smps_pkg::ST_XTAL, smps_pkg::ST_PFWAIT,
            smps_pkg::ST_SAMPLE, smps_pkg::ST_CONFIRM, smps_pkg::ST_EXTRST};
        halt_o = state_nxt inside {smps_pkg::ST_STOP, smps_pkg::ST_WAKE};  // [R1]
        pwr_o = state_nxt inside {smps_pkg::ST_XTAL, smps_pkg::ST_RUN,
            smps_pkg::ST_WAKE, smps_pkg::ST_EXTRST};  // [R14] [R17]
        mon_o = pwr_o  // [R5] [R9]
            || state_nxt inside {smps_pkg::ST_SAMPLE, smps_pkg::ST_CONFIRM}  // [R12]
            || (state_nxt == smps_pkg::ST_PFWAIT && sel == 2'h0)  // [R11]
            || (state_nxt == smps_pkg::ST_STOP && mon_stop);  // [R7]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_r <= smps_pkg::OUT_RST;
            boot_r <= smps_pkg::BOOT_RST;
        end else begin
            out_r <= {rst_o, halt_o, mon_o, pwr_o, pwr_o, state_nxt != smps_pkg::ST_POR};
            if (state_r == smps_pkg::ST_XTAL && state_nxt == smps_pkg::ST_RUN) begin
                boot_r <= smps_pkg::ROM_ENTRY;  // [R13]
            end
        end
    end

    // apb slave: one wait state, unmapped offsets answer pslverr
    always_comb begin
        case (paddr)
            smps_pkg::A_CTRL: rd_mux = {28'h0, ctrl_r};
            smps_pkg::A_WAKE: rd_mux = {15'h0, wake_r};
            smps_pkg::A_STAT: rd_mux = {20'h0, state_r, 5'h0, flag_r};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            seen_r <= 1'b1;
            pready_r <= acc;
            pslverr_r <= acc && !(paddr inside {smps_pkg::A_CTRL, smps_pkg::A_WAKE,
                smps_pkg::A_CMD, smps_pkg::A_STAT});
            if (acc && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    assign {cpu_reset, cpu_halt, monitor_on, regulator_on, crystal_on, sram_retain} = out_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign warn_irq = wirq_r;
    assign boot_addr = boot_r;

    // checks
    sequence s_stop_go;
        state_r == smps_pkg::ST_RUN && stop_req && !rst_f && !xrst_f && !por_f;
    endsequence
    sequence s_wake_go;
        state_r == smps_pkg::ST_STOP && !por_f && !xrst_f && !(mon_stop && rst_f)
            && (irq_f || wake_hit);
    endsequence
    sequence s_xtal_exit;
        state_r == smps_pkg::ST_XTAL ##1 state_r == smps_pkg::ST_RUN;
    endsequence

    stop_entry_a: assert property ( // [R1] [R19]
        s_stop_go |=> state_r == smps_pkg::ST_STOP && cpu_halt && sram_retain && !cpu_reset)
        else $error("stop request did not halt the cpu");
    stop_wake_a: assert property ( // [R2] [R3] [R9]
        s_wake_go |=> state_r == smps_pkg::ST_WAKE && monitor_on && cpu_halt)
        else $error("wake source did not start exit with monitor on");
    run_mon_a: assert property ( // [R5]
        state_r == smps_pkg::ST_RUN |-> monitor_on && regulator_on && !cpu_reset)
        else $error("monitor off while running");
    reset_dflt_a: assert property ( // [R6]
        !seen_r |-> ctrl_r[smps_pkg::B_MONOFF])
        else $error("monitor-off bit not set after reset");
    mon_off_a: assert property ( // [R7]
        state_r == smps_pkg::ST_STOP && !mon_stop && rst_f && !por_f && !xrst_f
            && !irq_f && !wake_hit |=> state_r == smps_pkg::ST_STOP && !monitor_on)
        else $error("disabled monitor still acted in stop");
    por_hold_a: assert property ( // [R8] [R18]
        por_f |=> state_r == smps_pkg::ST_POR && cpu_reset && !regulator_on && !monitor_on)
        else $error("low supply did not hold reset");
    exit_chk_a: assert property ( // [R10]
        state_r == smps_pkg::ST_WAKE && wake_done && !por_f |=> if ($past(rst_f))
            (state_r == smps_pkg::ST_PFWAIT && cpu_reset)
            else (state_r == smps_pkg::ST_RUN && (flag_r[0] || !$past(warn_f))))
        else $error("stop exit check wrong");
    interval_a: assert property ( // [R11] [R20]
        state_r == smps_pkg::ST_PFWAIT ##1 state_r == smps_pkg::ST_SAMPLE
            |-> $past(sel) == 2'h0 || $past(tick_r) == per_last($past(sel)))
        else $error("periodic interval length wrong");
    sample_len_a: assert property ( // [R12]
        state_r == smps_pkg::ST_SAMPLE ##1 state_r == smps_pkg::ST_CONFIRM
            |-> $past(tick_r) == 14'(smps_pkg::SAMPLE_TICKS - 1) && monitor_on)
        else $error("sample window not two ring periods");
    xtal_exit_a: assert property ( // [R13]
        s_xtal_exit |-> $past(cyc_r) == CNT_W'(XTAL_CYC - 1)
            && boot_addr == smps_pkg::ROM_ENTRY && !cpu_reset)
        else $error("release before warm-up or wrong start address");
    ext_rst_a: assert property ( // [R14] [R15]
        state_r == smps_pkg::ST_EXTRST |-> regulator_on && crystal_on && monitor_on
            && cyc_r < CNT_W'(smps_pkg::EXT_REL_CYC))
        else $error("non-fail reset powered down or overlong");
    warn_set_a: assert property ( // [R16]
        state_r == smps_pkg::ST_RUN && warn_f && !rst_f && !por_f && !xrst_f
            && warn_cnt_r == CNT_W'(smps_pkg::WARN_CYC - 1) |=> flag_r[0] && !cpu_reset)
        else $error("persistent warning not flagged");
    pf_entry_a: assert property ( // [R17]
        state_r == smps_pkg::ST_RUN && rst_f && !por_f |=> state_r == smps_pkg::ST_PFWAIT
            && cpu_reset && !regulator_on && !crystal_on && sram_retain)
        else $error("power-fail entry wrong");
endmodule : smps_top
`default_nettype wire

// file: smps_supply.sv
// supply comparator and ring oscillator model for the sequencer
`timescale 1ns/1ps
`default_nettype none
module smps_supply #(
    parameter int RING_HALF = 5
) (
    input wire logic pclk,
    input wire logic [1:0] level,
    output logic ring_osc,
    output logic por_low,
    output logic rst_low,
    output logic warn_low
);
    int cnt;
    initial begin
        ring_osc = 1'b0;
        cnt = 0;
    end
    // ring runs free, sped up so periodic sampling fits in the run
    always @(posedge pclk) begin
        cnt <= (cnt == RING_HALF - 1) ? 0 : cnt + 1;
        if (cnt == RING_HALF - 1) ring_osc <= ~ring_osc;
    end
    // levels nest: below por implies below reset implies below warning
    assign warn_low = (level != 2'h0);
    assign rst_low = level[1];
    assign por_low = (level == 2'h3);
endmodule : smps_supply
`default_nettype wire

// file: smps_test.sv
// self-checking bench for the stop mode power-fail sequencer
`timescale 1ns/1ps
`default_nettype none
module smps_test;
    localparam int RH = 5;
    logic pclk, presetn, psel, penable, pwrite, ext_irq, ext_reset_n, wdt_reset;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, err, ring_osc, por_low, rst_low, warn_low;
    logic cpu_reset, cpu_halt, monitor_on, regulator_on, crystal_on, sram_retain, warn_irq;
    logic [15:0] boot_addr;
    logic [1:0] level;
    logic [31:0] v;
    int miscompares, checks, n;
    smps_top #(.XTAL_CYC(8)) smps_top_i (.pclk, .presetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .ring_osc, .por_low, .rst_low,
        .warn_low, .ext_irq, .ext_reset_n, .wdt_reset, .cpu_reset, .cpu_halt,
        .monitor_on, .regulator_on, .crystal_on, .sram_retain, .warn_irq, .boot_addr);
    smps_supply #(.RING_HALF(RH)) smps_supply_i (.pclk, .level, .ring_osc, .por_low,
        .rst_low, .warn_low);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    function automatic logic pick(input int s);
        case (s)
            0: return cpu_reset;
            1: return cpu_halt;
            default: return monitor_on;
        endcase
    endfunction : pick
    // one periodic interval of 2^(10+s) ring ticks, in pclk cycles
    function automatic int per_cyc(input int s);
        return (1 << (10 + s)) * 2 * RH;
    endfunction : per_cyc
    // poll an output; values read right after the edge are the sampled ones
    task automatic wait_for(input int s, input logic val, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pick(s) !== val && n < lim);
        if (pick(s) !== val) begin
            miscompares++;
            end_sim();
        end
    endtask : wait_for
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            end_sim();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_irq, wdt_reset, level} = '0;
        ext_reset_n = 1'b1;
        miscompares = 0;
        checks = 0;
        v = $urandom(32'h7240);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wait_for(0, 1'b0, 100);
        check(32'(boot_addr), 32'h8000);
        check(32'({regulator_on, crystal_on, monitor_on}), 32'h7);
        apb(1'b0, smps_pkg::A_CTRL, 0);
        check(q, 32'h1);
        apb(1'b0, smps_pkg::A_STAT, 0);
        check(32'(q[11:0]), 32'h200);
        apb(1'b0, 8'h10, 0);
        check(32'(err), 32'h1);
        check(q, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'h1ffff : $urandom() & 32'h1ffff;
            apb(1'b1, smps_pkg::A_WAKE, v);
            apb(1'b0, smps_pkg::A_WAKE, 0);
            check(q, v);
        end
        apb(1'b1, smps_pkg::A_WAKE, 0);
        // warning must persist its full hold time before the flag sets
        apb(1'b1, smps_pkg::A_CTRL, 32'h9);
        level <= 2'h1;
        cyc(2400);
        check(32'(warn_irq), 0);
        cyc(200);
        check(32'({warn_irq, cpu_reset}), 32'h2);
        level <= 2'h0;
        // let the comparator settle first, a still-held warning beats the clear
        cyc(8);
        apb(1'b1, smps_pkg::A_STAT, 32'h7);
        apb(1'b0, smps_pkg::A_STAT, 0);
        check(32'({warn_irq, q[2:0]}), 0);
        // stop with monitor off ignores a reset-level supply until wake
        apb(1'b1, smps_pkg::A_CMD, 32'h1);
        level <= 2'h2;
        cyc(20);
        check(32'({cpu_halt, cpu_reset, monitor_on}), 32'h4);
        ext_irq <= 1'b1;
        wait_for(2, 1'b1, 50);
        check(32'({cpu_halt, cpu_reset}), 32'h2);
        wait_for(0, 1'b1, 100);
        ext_irq <= 1'b0;
        cyc(2);
        check(32'({regulator_on, crystal_on, sram_retain}), 32'h1);
        level <= 2'h0;
        wait_for(0, 1'b0, 500);
        check(32'(boot_addr), 32'h8000);
        apb(1'b0, smps_pkg::A_STAT, 0);
        check(32'({q[11:8], q[2]}), 32'h5);
        // timer wake three ticks on, flag set since warning is still present
        apb(1'b1, smps_pkg::A_STAT, 32'h7);
        apb(1'b1, smps_pkg::A_WAKE, 32'h10003);
        apb(1'b1, smps_pkg::A_CMD, 32'h1);
        level <= 2'h1;
        wait_for(1, 1'b0, 300);
        check(32'(n >= 4 * RH), 1);
        apb(1'b0, smps_pkg::A_STAT, 0);
        check(32'(q[1:0]), 32'h3);
        level <= 2'h0;
        apb(1'b1, smps_pkg::A_WAKE, 0);
        apb(1'b1, smps_pkg::A_STAT, 32'h7);
        // periodic sampling at 2^11 and 2^12 ticks; 2^13 would overrun the run
        for (int s = 1; s < 3; s++) begin
            apb(1'b1, smps_pkg::A_CTRL, 32'(s << 1));
            level <= 2'h2;
            wait_for(0, 1'b1, 50);
            cyc(2);
            check(32'({monitor_on, regulator_on}), 0);
            level <= 2'h0;
            wait_for(2, 1'b1, per_cyc(s) + 1000);
            check(32'(n >= per_cyc(s) - 4 * RH), 1);
            wait_for(0, 1'b0, 100);
        end
        // monitor on in stop: a warning wakes the cpu
        apb(1'b1, smps_pkg::A_CMD, 32'h1);
        level <= 2'h1;
        wait_for(1, 1'b0, 300);
        apb(1'b0, smps_pkg::A_STAT, 0);
        check(32'({q[11:8], q[0]}), 32'h5);
        level <= 2'h0;
        // pin and watchdog resets keep power up and release quickly
        for (int i = 0; i < 2; i++) begin
            if (i == 0) ext_reset_n <= 1'b0;
            else wdt_reset <= 1'b1;
            cyc(10);
            check(32'({cpu_reset, regulator_on, crystal_on, monitor_on}), 32'hf);
            ext_reset_n <= 1'b1;
            wdt_reset <= 1'b0;
            wait_for(0, 1'b0, 20);
        end
        // supply below por inside stop still resets, everything powered down
        apb(1'b1, smps_pkg::A_CTRL, 32'h1);
        apb(1'b1, smps_pkg::A_CMD, 32'h1);
        level <= 2'h3;
        cyc(10);
        check(32'({cpu_reset, regulator_on, crystal_on, monitor_on, sram_retain}), 32'h10);
        level <= 2'h0;
        wait_for(0, 1'b0, 100);
        apb(1'b0, smps_pkg::A_STAT, 0);
        check(32'(q[11:8]), 32'h2);
        end_sim();
    end
endmodule : smps_test
`default_nettype wire
